// ---- pgpsc_ep_model.sv ----
// Partner model: endpoint link status returned to the control block
`timescale 1ns/1ps
module pgpsc_ep_model (
    // Clock, reset and recovery request
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic force_recovery_i,
    // Scenario knobs
    input wire logic gen2_cap_i,
    input wire logic slow_i,
    // Status towards the root port
    output logic [5:0] link_state_o,
    output logic partner_gen2_o
);
    logic [7:0] wait_r;
    always_ff @(posedge mclk_i) begin
        if (rst_i || wait_r == 8'h01) begin
            link_state_o <= pgpsc_pkg::LINK_STATE_L0;
        end else if (force_recovery_i) begin
            link_state_o <= 6'h0D;
        end
        if (rst_i) begin
            wait_r <= 8'h00;
        end else if (force_recovery_i) begin
            wait_r <= slow_i ? 8'h28 : 8'h04;
        end else if (wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
        end
    end
    // Gen2 capability only shows once the link is back in L0
    assign partner_gen2_o = gen2_cap_i && link_state_o == 6'h10;
endmodule : pgpsc_ep_model

// ---- pgpsc_pkg.sv ----
// Package: register map, field positions, reset values and timing counts
package pgpsc_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_DEBUG_FIX = 8'h02;
    localparam logic [7:0] IDX_PDN_CLK_SEL = 8'h07;
    localparam logic [7:0] IDX_STRAP_B_GPP = 8'h22;
    localparam logic [7:0] IDX_PLL_PDN = 8'h2E;
    localparam logic [7:0] IDX_STRAP_IDLE = 8'h34;
    localparam logic [7:0] IDX_STRAP_CDE = 8'h37;
    localparam logic [7:0] IDX_REFCLK_BUF = 8'h38;
    localparam logic [7:0] IDX_STRAP_A = 8'h39;
    localparam logic [7:0] IDX_PAD_PLL_PWR = 8'h40;
    localparam logic [7:0] IDX_LINK_CAPABILITY = 8'h64;
    localparam logic [7:0] IDX_LANE_PDN = 8'h65;
    localparam logic [7:0] IDX_LINK_CTL = 8'h68;
    localparam logic [7:0] IDX_LINK_CTL2 = 8'h88;
    localparam logic [7:0] IDX_LC_TIMERS = 8'hA0;
    localparam logic [7:0] IDX_TRAINING = 8'hA1;
    localparam logic [7:0] IDX_WIDTH = 8'hA2;
    localparam logic [7:0] IDX_SPEED = 8'hA4;
    localparam logic [7:0] IDX_STATE = 8'hA5;

    // ----------------------------------------------------------------
    // Writable register slots
    // ----------------------------------------------------------------
    localparam int NSLOT = 16;
    localparam int S_PDN_CLK = 1;
    localparam int S_PLL_PDN = 3;
    localparam int S_IDLE = 4;
    localparam int S_REFCLK = 6;
    localparam int S_PCTL = 8;
    localparam int S_LANE = 9;
    localparam int S_LCTL = 10;
    localparam int S_TIMERS = 12;
    localparam int S_TRAIN = 13;
    localparam int S_WIDTH = 14;
    localparam int S_SPEED = 15;
    localparam logic [7:0] SLOT_IDX [NSLOT] = '{
        IDX_DEBUG_FIX, IDX_PDN_CLK_SEL, IDX_STRAP_B_GPP, IDX_PLL_PDN,
        IDX_STRAP_IDLE, IDX_STRAP_CDE, IDX_REFCLK_BUF, IDX_STRAP_A,
        IDX_PAD_PLL_PWR, IDX_LANE_PDN, IDX_LINK_CTL, IDX_LINK_CTL2,
        IDX_LC_TIMERS, IDX_TRAINING, IDX_WIDTH, IDX_SPEED};
    localparam logic [31:0] SLOT_RST [NSLOT] = '{
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h4000_0000, 32'h0000_0000, 32'h1000_0000, 32'h0000_0000,
        32'h0000_0210, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    localparam logic [31:0] SLOT_WMASK [NSLOT] = '{
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFEFB_FF7F};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PERM_SEL_BIT = 16;
    localparam int SNDRCV_SEL_LO = 12;
    localparam int PADCLK_SEL_LO = 20;
    localparam logic [1:0] PADCLK_PLL_C = 2'b10;
    localparam logic [1:0] PADCLK_PLL_A = 2'b00;
    localparam int REFCLK_RX_BIT = 28;
    localparam int IDLE_DET_BIT = 30;
    localparam int PLL_FULL_LO = 4;
    localparam int PLL_TXBUF_LO = 16;
    localparam int PLL_RXBUF_LO = 20;
    localparam int LANE_TX_LO = 0;
    localparam int LANE_RX_LO = 8;
    localparam int LANE_REV_BIT = 20;
    localparam int UPCFG_DIS_BIT = 13;
    localparam int GEN2_STRAP_BIT = 0;
    localparam int START_SPD_BIT = 7;
    localparam int FORCE_REC_BIT = 18;
    localparam int PARTNER_GEN2_BIT = 24;
    localparam int ASPM_L1_BIT = 1;
    localparam int BLOCK_L0S_BIT = 11;
    localparam int L0S_IDLE_LO = 8;
    localparam int PWRDN_EN_BIT = 0;
    localparam int PLL_OFF_LP_BIT = 3;
    localparam int BUF_KEEP_N_BIT = 4;
    localparam int PLL_KEEP_N_BIT = 9;
    localparam int RXFE_OFF_BIT = 12;
    localparam int STAB_FIX_BIT = 8;
    localparam logic [5:0] LINK_STATE_L0 = 6'h10;

    // Configuration cases that allow lane reversal (bit n = case n)
    localparam logic [17:0] REV_OK_CASES = 18'h2403E;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [3:0] L0S_CODE_10US = 4'h8;
    localparam int L0S_10US_NS = 10000;
    localparam int L0S_10US_TICKS = L0S_10US_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rx_pd;
        logic [15:0] tx_pd;
    } pgpsc_lane_pd_t;

    typedef struct packed {
        logic [2:0] rx_buf_pd;
        logic [2:0] tx_buf_pd;
        logic [2:0] full_pd;
    } pgpsc_pll_pd_t;

endpackage : pgpsc_pkg

// ---- pgpsc_top.sv ----
// Power, clock-source and link-management control with APB registers
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps

module pgpsc_top #(
    parameter int NUM_PORTS = 2,
    parameter logic [3:0] MAX_LINK_SPEED = 4'h2
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Link core status
    input wire logic [5:0] link_state_i,
    input wire logic partner_gen2_i,
    input wire logic tx_idle_i,
    input wire logic l1_armed_i,
    input wire logic [NUM_PORTS-1:0] port_in_l1_i,
    input wire logic other_ports_l1_en_i,
    // Configuration case straps from pins
    input wire logic [4:0] config_case_i,
    // Clock source selects (1 = PLL C)
    output logic perm_clock_src_sel_o,
    output logic [3:0] sendrecv_clock_src_sel_o,
    output logic [2:0] pad_data_clock_src_sel_o,
    // Analog enables and power-down
    output logic refclk_receiver_enable_o,
    output logic idle_detector_enable_o,
    output pgpsc_pkg::pgpsc_lane_pd_t lane_pd_o,
    output pgpsc_pkg::pgpsc_pll_pd_t pll_pd_o,
    output logic pll_l1_off_o,
    output logic pll_buf_l1_off_o,
    output logic rx_frontend_off_o,
    // Link control
    output logic lane_reverse_o,
    output logic gen2_enable_strap_o,
    output logic upconfigure_disable_o,
    output logic force_recovery_o,
    output logic start_speed_change_o,
    output logic tx_l0s_o
);

    // ----------------------------------------------------------------
    // Register file and APB slave
    // ----------------------------------------------------------------
    logic [31:0] reg_r [pgpsc_pkg::NSLOT];
    logic [31:0] reg_nxt [pgpsc_pkg::NSLOT];
    logic pready_r, pready_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic force_rec_r, force_rec_nxt;
    logic start_spd_r, start_spd_nxt;
    logic [31:0] wmask;
    logic [7:0] acc_idx;
    logic hit;
    logic wr_go;
    logic [5:0] link_state;

    assign acc_idx = paddr_i[9:2];
    assign link_state = link_state_i;
    assign wr_go = psel_i && penable_i && pready_r && pwrite_i &&
        !pslverr_r;

    always_comb begin
        wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}},
                 {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
        hit = 1'b0;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        force_rec_nxt = 1'b0;
        start_spd_nxt = 1'b0;
        for (int s = 0; s < pgpsc_pkg::NSLOT; s++) begin
            reg_nxt[s] = reg_r[s];
        end
        // Setup phase: decode and capture read data for the access phase
        if (psel_i && !penable_i) begin
            pready_nxt = 1'b1;
            prdata_nxt = 32'h0000_0000;
            if (paddr_i[11:10] != 2'b00 || paddr_i[1:0] != 2'b00) begin
                hit = 1'b0;
            end else if (acc_idx == pgpsc_pkg::IDX_LINK_CAPABILITY) begin
                hit = 1'b1;
                prdata_nxt = {28'h0000000, MAX_LINK_SPEED};
            end else if (acc_idx == pgpsc_pkg::IDX_STATE) begin
                hit = 1'b1;
                prdata_nxt = {26'h0000000, link_state};
            end else begin
                for (int s = 0; s < pgpsc_pkg::NSLOT; s++) begin
                    if (acc_idx == pgpsc_pkg::SLOT_IDX[s]) begin
                        hit = 1'b1;
                        prdata_nxt = reg_r[s];
                    end
                end
                if (acc_idx == pgpsc_pkg::IDX_SPEED) begin
                    prdata_nxt[pgpsc_pkg::PARTNER_GEN2_BIT] =
                        partner_gen2_i;
                end
            end
            pslverr_nxt = !hit;
            if (!pwrite_i && !hit) begin
                prdata_nxt = 32'h0000_0000;
            end
        end else if (psel_i && penable_i && !pready_r) begin
            pready_nxt = 1'b1;
            pslverr_nxt = pslverr_r;
        end
        // Access phase: a write commits on the completing edge only
        if (wr_go) begin
            for (int s = 0; s < pgpsc_pkg::NSLOT; s++) begin
                if (acc_idx == pgpsc_pkg::SLOT_IDX[s]) begin
                    reg_nxt[s] = (reg_r[s] & ~(wmask &
                        pgpsc_pkg::SLOT_WMASK[s])) | (pwdata_i & wmask &
                        pgpsc_pkg::SLOT_WMASK[s]);
                end
            end
            if (acc_idx == pgpsc_pkg::IDX_SPEED) begin
                force_rec_nxt = pstrb_i[2] &&
                    pwdata_i[pgpsc_pkg::FORCE_REC_BIT];
                start_spd_nxt = pstrb_i[0] &&
                    pwdata_i[pgpsc_pkg::START_SPD_BIT] &&
                    (link_state == pgpsc_pkg::LINK_STATE_L0) &&
                    partner_gen2_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int s = 0; s < pgpsc_pkg::NSLOT; s++) begin
                reg_r[s] <= pgpsc_pkg::SLOT_RST[s];
            end
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            force_rec_r <= 1'b0;
            start_spd_r <= 1'b0;
        end else begin
            for (int s = 0; s < pgpsc_pkg::NSLOT; s++) begin
                reg_r[s] <= reg_nxt[s];
            end
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            force_rec_r <= force_rec_nxt;
            start_spd_r <= start_spd_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Strap synchroniser
    // ----------------------------------------------------------------
    logic [4:0] case_meta_r, case_sync_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            case_meta_r <= 5'h00;
            case_sync_r <= 5'h00;
        end else begin
            case_meta_r <= config_case_i;
            case_sync_r <= case_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Clock source, power-down and link control outputs
    // ----------------------------------------------------------------
    logic [31:0] clk_reg, pctl_reg, lane_reg, pll_reg, spd_reg;
    logic pll_a_up, pll_c_up;
    logic [9:0] src_nxt, src_r;
    logic [31:0] lpd_nxt, lpd_r;
    logic [2:0] l1_nxt, l1_r;
    logic rev_nxt, rev_r;
    logic [31:0] rev_ok;

    // Case codes past the table read as unsupported, never unknown
    assign rev_ok = {14'h0000, pgpsc_pkg::REV_OK_CASES};
    assign clk_reg = reg_r[pgpsc_pkg::S_PDN_CLK];
    assign pctl_reg = reg_r[pgpsc_pkg::S_PCTL];
    assign lane_reg = reg_r[pgpsc_pkg::S_LANE];
    assign pll_reg = reg_r[pgpsc_pkg::S_PLL_PDN];
    assign spd_reg = reg_r[pgpsc_pkg::S_SPEED];
    assign pll_a_up = !pll_reg[pgpsc_pkg::PLL_FULL_LO];
    assign pll_c_up = !pll_reg[pgpsc_pkg::PLL_FULL_LO + 2];

    // Keeps the core on a live PLL: a stopped choice falls back
    function automatic logic pick_c(input logic want_c, input logic a_up,
                                    input logic c_up);
        pick_c = want_c ? (c_up || !a_up) : (!a_up && c_up);
    endfunction : pick_c

    always_comb begin
        src_nxt[0] = pick_c(clk_reg[pgpsc_pkg::PERM_SEL_BIT],
                            pll_a_up, pll_c_up);
        for (int i = 0; i < 4; i++) begin
            src_nxt[1+i] = pick_c(clk_reg[pgpsc_pkg::SNDRCV_SEL_LO+i],
                                  pll_a_up, pll_c_up);
        end
        for (int i = 0; i < 3; i++) begin
            src_nxt[5+i] = pick_c(
                clk_reg[pgpsc_pkg::PADCLK_SEL_LO+2*i +: 2] ==
                pgpsc_pkg::PADCLK_PLL_C, pll_a_up, pll_c_up);
        end
        src_nxt[8] = reg_r[pgpsc_pkg::S_REFCLK][pgpsc_pkg::REFCLK_RX_BIT];
        src_nxt[9] = reg_r[pgpsc_pkg::S_IDLE][pgpsc_pkg::IDLE_DET_BIT];
        // PLL off in L1 needs every port armed for and resting in L1
        l1_nxt[0] = pctl_reg[pgpsc_pkg::PWRDN_EN_BIT] &&
            pctl_reg[pgpsc_pkg::PLL_OFF_LP_BIT] &&
            !pctl_reg[pgpsc_pkg::PLL_KEEP_N_BIT] &&
            reg_r[pgpsc_pkg::S_LCTL][pgpsc_pkg::ASPM_L1_BIT] &&
            other_ports_l1_en_i && (&port_in_l1_i);
        l1_nxt[1] = l1_nxt[0] && !pctl_reg[pgpsc_pkg::BUF_KEEP_N_BIT];
        l1_nxt[2] = l1_nxt[0] && pctl_reg[pgpsc_pkg::RXFE_OFF_BIT];
        rev_nxt = reg_r[pgpsc_pkg::S_WIDTH][pgpsc_pkg::LANE_REV_BIT] &&
            rev_ok[case_sync_r];
        lpd_nxt = 32'h0000_0000;
    end

    // Per lane: one control bit per lane pair
    logic [15:0] lpd_nxt_lane_tx, lpd_nxt_lane_rx;
    for (genvar ln = 0; ln < 16; ln++) begin : g_lane
        assign lpd_nxt_lane_tx[ln] =
            lane_reg[pgpsc_pkg::LANE_TX_LO + ln/2];
        assign lpd_nxt_lane_rx[ln] =
            lane_reg[pgpsc_pkg::LANE_RX_LO + ln/2];
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            src_r <= 10'h300;
            lpd_r <= 32'h0000_0000;
            l1_r <= 3'b000;
            rev_r <= 1'b0;
        end else begin
            src_r <= src_nxt;
            lpd_r <= {lpd_nxt_lane_rx, lpd_nxt_lane_tx} | lpd_nxt;
            l1_r <= l1_nxt;
            rev_r <= rev_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Transmit L0s inactivity timer
    // ----------------------------------------------------------------
    localparam logic [15:0] L0S_TICKS = 16'(pgpsc_pkg::L0S_10US_TICKS);
    logic [15:0] idle_cnt_r, idle_cnt_nxt;
    logic tx_l0s_r, tx_l0s_nxt;
    logic [31:0] tmr_reg;
    logic block_l0s;

    assign tmr_reg = reg_r[pgpsc_pkg::S_TIMERS];
    assign block_l0s = reg_r[pgpsc_pkg::S_TRAIN][pgpsc_pkg::BLOCK_L0S_BIT]
        && l1_armed_i;

    always_comb begin
        idle_cnt_nxt = 16'h0000;
        tx_l0s_nxt = 1'b0;
        if (tx_idle_i && tmr_reg[pgpsc_pkg::L0S_IDLE_LO +: 4] ==
            pgpsc_pkg::L0S_CODE_10US) begin
            idle_cnt_nxt = (idle_cnt_r < L0S_TICKS) ?
                idle_cnt_r + 16'h0001 : idle_cnt_r;
            tx_l0s_nxt = tx_l0s_r ||
                (idle_cnt_nxt >= L0S_TICKS && !block_l0s);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            idle_cnt_r <= 16'h0000;
            tx_l0s_r <= 1'b0;
        end else begin
            idle_cnt_r <= idle_cnt_nxt;
            tx_l0s_r <= tx_l0s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Output drive
    // ----------------------------------------------------------------
    assign pready_o = pready_r;
    assign prdata_o = prdata_r;
    assign pslverr_o = pslverr_r;
    assign perm_clock_src_sel_o = src_r[0];
    assign sendrecv_clock_src_sel_o = src_r[4:1];
    assign pad_data_clock_src_sel_o = src_r[7:5];
    assign refclk_receiver_enable_o = src_r[8];
    assign idle_detector_enable_o = src_r[9];
    assign lane_pd_o = lpd_r;
    assign pll_pd_o = {pll_reg[pgpsc_pkg::PLL_RXBUF_LO +: 3],
        pll_reg[pgpsc_pkg::PLL_TXBUF_LO +: 3],
        pll_reg[pgpsc_pkg::PLL_FULL_LO +: 3]};
    assign pll_l1_off_o = l1_r[0];
    assign pll_buf_l1_off_o = l1_r[1];
    assign rx_frontend_off_o = l1_r[2];
    assign lane_reverse_o = rev_r;
    assign gen2_enable_strap_o = spd_reg[pgpsc_pkg::GEN2_STRAP_BIT];
    assign upconfigure_disable_o =
        reg_r[pgpsc_pkg::S_WIDTH][pgpsc_pkg::UPCFG_DIS_BIT];
    assign force_recovery_o = force_rec_r;
    assign start_speed_change_o = start_spd_r;
    assign tx_l0s_o = tx_l0s_r;

endmodule : pgpsc_top

// ---- pgpsc_top_fix.sv ----
// Intentionally empty

// ---- pgpsc_top_properties.sv ----
// Checker: timing properties at the control block ports
`timescale 1ns/1ps
module pgpsc_top_properties #(
    parameter int NUM_PORTS = 2
) (
    // Clock, reset and APB
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Link status and control
    input wire logic [5:0] link_state_i,
    input wire logic partner_gen2_i,
    input wire logic tx_idle_i,
    input wire logic [NUM_PORTS-1:0] port_in_l1_i,
    input wire logic other_ports_l1_en_i,
    input wire logic force_recovery_o,
    input wire logic start_speed_change_o,
    input wire logic pll_l1_off_o,
    input wire logic tx_l0s_o
);
    localparam int L0S_MIN = pgpsc_pkg::L0S_10US_TICKS - 2;
    logic [9:0] idle_cnt_r;
    logic [9:0] idle_cnt_nxt;
    logic rec_wr;
    // Run length of transmitter idle, saturating
    assign idle_cnt_nxt = (rst_i || !tx_idle_i) ? 10'h000 :
        idle_cnt_r + {9'h000, idle_cnt_r != 10'h3FF};
    always_ff @(posedge mclk_i) idle_cnt_r <= idle_cnt_nxt;
    assign rec_wr = psel_i && penable_i && pready_o && pwrite_i &&
        paddr_i == {2'b00, pgpsc_pkg::IDX_SPEED, 2'b00} && pwdata_i[18];
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready held past one cycle");
    a_ready_after_setup: assert property (
        psel_i && !penable_i |=> pready_o) else $error("no answer to setup");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_recovery_cause: assert property (
        force_recovery_o |-> $past(rec_wr)) else $error("stray recovery");
    a_recovery_pulse: assert property (
        force_recovery_o |=> !force_recovery_o) else $error("long recovery");
    a_start_in_l0: assert property (start_speed_change_o |->
        $past(link_state_i) == pgpsc_pkg::LINK_STATE_L0 &&
        $past(partner_gen2_i)) else $error("speed change outside L0");
    a_pll_all_l1: assert property (pll_l1_off_o |->
        $past(&port_in_l1_i && other_ports_l1_en_i))
        else $error("pll off while a port is awake");
    a_l0s_entry_time: assert property (
        $rose(tx_l0s_o) |-> idle_cnt_r >= L0S_MIN) else $error("early l0s");
    a_l0s_exit_next: assert property (
        !tx_idle_i |=> !tx_l0s_o) else $error("l0s held while busy");
    c_recovery: cover property (force_recovery_o);
    c_l0s: cover property ($rose(tx_l0s_o));
    c_pll_off: cover property (pll_l1_off_o);
endmodule : pgpsc_top_properties

bind pgpsc_top pgpsc_top_properties #(.NUM_PORTS(NUM_PORTS)) i_props (
    .mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .pslverr_o, .link_state_i, .partner_gen2_i, .tx_idle_i,
    .port_in_l1_i, .other_ports_l1_en_i, .force_recovery_o,
    .start_speed_change_o, .pll_l1_off_o, .tx_l0s_o);

// ---- tb_top.sv ----
// Testbench: register access and control scenarios for the block
`timescale 1ns/1ps
module tb_top;
    logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, tx_idle_i = 1'b0, l1_armed_i = 1'b0;
    logic other_ports_l1_en_i = 1'b0, gen2_cap = 1'b1, slow = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [3:0] pstrb_i = 4'hF;
    logic [1:0] port_in_l1_i = 2'b00;
    logic [4:0] config_case_i = 5'h00;
    logic pready_o, pslverr_o, partner_gen2_i, perm_clock_src_sel_o;
    logic refclk_receiver_enable_o, idle_detector_enable_o, pll_l1_off_o;
    logic pll_buf_l1_off_o, rx_frontend_off_o, lane_reverse_o, tx_l0s_o;
    logic force_recovery_o, start_speed_change_o;
    logic [31:0] prdata_o;
    logic [5:0] link_state_i;
    logic [2:0] pad_data_clock_src_sel_o;
    logic gen2_enable_strap_o, upconfigure_disable_o;
    pgpsc_pkg::pgpsc_lane_pd_t lane_pd_o;
    logic [3:0] sendrecv_clock_src_sel_o;
    pgpsc_pkg::pgpsc_pll_pd_t pll_pd_o;
    logic [64:0] note;
    logic [64:0] exp_q[$];
    int bad_count = 0, comparisons = 0, rec_seen = 0, start_seen = 0;
    always #10 mclk_i = ~mclk_i;
    pgpsc_top i_dut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o,
        .link_state_i, .partner_gen2_i, .tx_idle_i, .l1_armed_i,
        .port_in_l1_i, .other_ports_l1_en_i, .config_case_i,
        .perm_clock_src_sel_o, .sendrecv_clock_src_sel_o,
        .pad_data_clock_src_sel_o, .refclk_receiver_enable_o,
        .idle_detector_enable_o, .lane_pd_o, .pll_pd_o, .pll_l1_off_o,
        .pll_buf_l1_off_o, .rx_frontend_off_o, .lane_reverse_o,
        .gen2_enable_strap_o, .upconfigure_disable_o,
        .force_recovery_o, .start_speed_change_o, .tx_l0s_o);
    pgpsc_ep_model i_ep (.mclk_i, .rst_i, .force_recovery_i(force_recovery_o),
        .gen2_cap_i(gen2_cap), .slow_i(slow), .link_state_o(link_state_i),
        .partner_gen2_o(partner_gen2_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // APB transfer; a read leaves its expected word, mask and error
    task automatic xfer(input logic wr, input logic [7:0] idx,
            input logic [31:0] d, input logic [31:0] m, input logic err);
        int n;
        n = 0;
        if (!wr) exp_q.push_back({err, m, d});
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= wr ? d : 32'h0000_0000;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) bad_count++;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : xfer
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : settle
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    always @(posedge mclk_i) begin
        if (force_recovery_o === 1'b1) rec_seen++;
        if (start_speed_change_o === 1'b1) start_seen++;
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            note = exp_q.pop_front();
            chk(prdata_o & note[63:32], note[31:0]);
            chk(pslverr_o, note[64]);
        end
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        conclude();
    end
    initial begin
        logic [31:0] rv;
        void'($urandom(79));
        rv = $urandom();
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        settle(1);
        chk({refclk_receiver_enable_o, idle_detector_enable_o}, 2'b11);
        xfer(1'b0, 8'h38, 32'h1000_0000, '1, 1'b0);
        xfer(1'b0, 8'h40, 32'h0000_0210, '1, 1'b0);
        xfer(1'b1, 8'h64, rv, '1, 1'b0);
        xfer(1'b0, 8'h64, 32'h2, '1, 1'b0);
        xfer(1'b0, 8'h01, 32'h0, '1, 1'b1);
        xfer(1'b1, 8'h39, rv, '1, 1'b0);
        xfer(1'b0, 8'h39, rv, '1, 1'b0);
        xfer(1'b1, 8'h07, 32'h02A1_F000, '1, 1'b0);
        settle(2);
        chk({perm_clock_src_sel_o, sendrecv_clock_src_sel_o,
            pad_data_clock_src_sel_o}, 8'hFF);
        xfer(1'b1, 8'h2E, 32'h0044_0040, '1, 1'b0);
        settle(2);
        chk({perm_clock_src_sel_o, pll_pd_o}, 10'h124);
        xfer(1'b1, 8'h2E, 32'h0011_0010, '1, 1'b0);
        settle(2);
        chk({perm_clock_src_sel_o, pll_pd_o}, 10'h249);
        xfer(1'b1, 8'h2E, 32'h0, '1, 1'b0);
        xfer(1'b1, 8'h38, 32'h0, '1, 1'b0);
        xfer(1'b1, 8'h34, 32'h0, '1, 1'b0);
        settle(2);
        chk({refclk_receiver_enable_o, idle_detector_enable_o}, 2'b00);
        xfer(1'b1, 8'h65, 32'h0000_F0F0 & 32'h0000_3C3C, '1, 1'b0);
        xfer(1'b1, 8'h2E, 32'h0040_0000, '1, 1'b0);
        settle(2);
        chk(lane_pd_o, 32'h0F00_0F00);
        chk(pll_pd_o, 9'h100);
        xfer(1'b1, 8'hA2, 32'h0000_2000, '1, 1'b0);
        settle(2);
        chk({gen2_enable_strap_o, upconfigure_disable_o}, 2'b01);
        xfer(1'b1, 8'hA4, 32'h0000_0001, '1, 1'b0);
        xfer(1'b1, 8'h39, 32'h8000_0000, '1, 1'b0);
        xfer(1'b1, 8'hA2, 32'h0000_0000, '1, 1'b0);
        xfer(1'b1, 8'h88, 32'h0000_0002, '1, 1'b0);
        settle(2);
        chk({gen2_enable_strap_o, upconfigure_disable_o}, 2'b10);
        slow <= 1'b1;
        xfer(1'b1, 8'hA4, 32'h0004_0001, '1, 1'b0);
        settle(3);
        chk(rec_seen, 1);
        xfer(1'b0, 8'hA5, 32'h0D, 32'h3F, 1'b0);
        settle(60);
        xfer(1'b0, 8'hA5, 32'h10, 32'h3F, 1'b0);
        xfer(1'b0, 8'hA4, 32'h0100_0001, 32'h0104_0081, 1'b0);
        xfer(1'b1, 8'hA4, 32'h81, '1, 1'b0);
        gen2_cap <= 1'b0;
        xfer(1'b1, 8'hA4, 32'h81, '1, 1'b0);
        settle(3);
        chk(start_seen, 1);
        xfer(1'b1, 8'h40, 32'h0000_1009, '1, 1'b0);
        xfer(1'b1, 8'h02, 32'h0000_0100, '1, 1'b0);
        xfer(1'b1, 8'h68, 32'h2, '1, 1'b0);
        other_ports_l1_en_i <= 1'b1;
        port_in_l1_i <= 2'b11;
        settle(3);
        chk({pll_l1_off_o, pll_buf_l1_off_o, rx_frontend_off_o}, 3'h7);
        port_in_l1_i <= 2'b01;
        settle(2);
        chk(pll_l1_off_o, 1'b0);
        xfer(1'b1, 8'hA0, 32'h0000_0800, '1, 1'b0);
        tx_idle_i <= 1'b1;
        settle(490);
        chk(tx_l0s_o, 1'b0);
        settle(20);
        chk(tx_l0s_o, 1'b1);
        tx_idle_i <= 1'b0;
        xfer(1'b1, 8'hA1, 32'h0000_0800, '1, 1'b0);
        l1_armed_i <= 1'b1;
        tx_idle_i <= 1'b1;
        settle(520);
        chk(tx_l0s_o, 1'b0);
        tx_idle_i <= 1'b0;
        xfer(1'b1, 8'hA2, 32'h0010_0000, '1, 1'b0);
        for (int c = 0; c < 18; c++) begin
            config_case_i <= c[4:0];
            settle(5);
            chk(lane_reverse_o, c inside {1, 2, 3, 4, 5, 14, 17});
        end
        conclude();
    end
endmodule : tb_top
